// File: common/fmcf_pkg.sv
package fmcf_pkg;

  // register addresses, reached through the address pointer
  localparam logic [7:0] REG_EXT_CFG     = 8'h7C;
  localparam logic [7:0] REG_PIN_FUNC    = 8'h7D;
  localparam logic [7:0] REG_MAX_DUTY    = 8'h38;
  localparam logic [7:0] REG_TEMP_OFFSET = 8'h70;
  localparam logic [7:0] REG_TEMP_LIMIT  = 8'h6A;
  localparam logic [7:0] REG_STATUS2     = 8'h42;

  localparam logic [6:0] SMB_DEV_ADDR = 7'h2E;

  // reset values
  localparam logic [7:0] EXT_CFG_RST     = 8'h01;
  localparam logic [7:0] PIN_FUNC_RST    = 8'h00;
  localparam logic [7:0] MAX_DUTY_RST    = 8'hFF;
  localparam logic [7:0] TEMP_OFFSET_RST = 8'h00;
  localparam logic [7:0] TEMP_LIMIT_RST  = 8'h64;
  localparam logic [7:0] PTR_RST         = 8'h00;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // field positions
  localparam int EXT_LEGACY_BIT   = 0;
  localparam int EXT_LOWFREQ_BIT  = 1;
  localparam int EXT_GPIO_DIR_BIT = 2;
  localparam int EXT_GPIO_POL_BIT = 3;
  localparam int PF_SEL_LSB       = 0;
  localparam int PF_SEL_MSB       = 1;
  localparam int PF_GPIO_OUT_BIT  = 2;
  localparam int ST2_PIN_BIT      = 5;

  // fan duty codes
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_OFF  = 8'h00;

  // extended range stores celsius plus this offset
  localparam logic [9:0] TEMP_EXT_OFFSET = 10'h040;

  // timing
  localparam int CLK_HZ           = 40_000_000;
  localparam int FAILSAFE_TIME_MS = 4600;
  localparam int FAILSAFE_CYCLES  = FAILSAFE_TIME_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    FMCF_PIN_FOURTH_TACH = 2'b00,
    FMCF_PIN_THERMAL     = 2'b01,
    FMCF_PIN_ALERT       = 2'b10,
    FMCF_PIN_GPIO        = 2'b11
  } fmcf_pin_fn_t;

  typedef enum logic [2:0] {
    FMCF_IDLE,
    FMCF_PTR,
    FMCF_DATA,
    FMCF_EXTRA,
    FMCF_READ
  } fmcf_txn_t;

  // both encodings onto one signed celsius scale
  function automatic logic signed [9:0] fmcf_to_celsius(input logic [7:0] code, input logic legacy);
    if (legacy) begin
      return {{2{code[7]}}, code};
    end
    return $signed({2'b00, code} - TEMP_EXT_OFFSET);
  endfunction

endpackage

// File: rtl/fmcf_sync.sv
`timescale 1ns/100ps
module fmcf_sync
  import fmcf_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule // fmcf_sync

// File: rtl/fmcf_failsafe_timer.sv
`timescale 1ns/100ps
module fmcf_failsafe_timer
  import fmcf_pkg::*;
#(
  parameter int CYCLES = FAILSAFE_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic cancel,
  output logic      expired
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count_reg;
  logic          running_reg;
  logic          cancelled_reg;

  // once addressed, the timer never rearms
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cancelled_reg <= 1'b0;
    end else if (cancel) begin
      cancelled_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running_reg <= 1'b0;
      count_reg   <= '0;
      expired     <= 1'b0;
    end else if (cancel || cancelled_reg) begin
      running_reg <= 1'b0;
      expired     <= 1'b0;
    end else if (start) begin
      running_reg <= 1'b1;
      count_reg   <= '0;
      expired     <= 1'b0;
    end else if (running_reg) begin
      if (count_reg == LAST) begin
        running_reg <= 1'b0;
        expired     <= 1'b1;
      end else begin
        count_reg <= count_reg + 1'b1;
      end
    end else begin
      // one-cycle pulse: a level would re-arm fail-safe after a host write
      expired <= 1'b0;
    end
  end

endmodule // fmcf_failsafe_timer

// File: rtl/fmcf_top.sv
`timescale 1ns/100ps
module fmcf_top
  import fmcf_pkg::*;
#(
  parameter int FAILSAFE_CNT = FAILSAFE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       vcc_good,
  input  wire logic       proc_rail_good,
  input  wire logic       smb_addr_valid,
  input  wire logic [6:0] smb_addr,
  input  wire logic       smb_addr_rw,
  output logic            smb_addr_ack,
  input  wire logic       smb_wr_valid,
  input  wire logic [7:0] smb_wr_data,
  input  wire logic       smb_rd_req,
  output logic [7:0]      smb_rd_data,
  output logic            smb_rd_valid,
  input  wire logic       smb_stop,
  input  wire logic       temp_valid,
  input  wire logic [7:0] temp_code,
  input  wire logic [7:0] loop_duty,
  input  wire logic       alert_req,
  input  wire logic       pin9_in,
  output logic            pin9_out,
  output logic            pin9_oe,
  output logic            fourth_tach_input,
  output logic            thermal_limit_pin,
  output logic            monitor_enable,
  output logic            legacy_range,
  output logic            low_freq_drive,
  output logic [7:0]      temp_offset,
  output logic [7:0]      fan_duty,
  output logic            fan_full_speed
);

  logic [7:0]    ext_cfg_reg;
  logic [7:0]    pin_func_reg;
  logic [7:0]    max_duty_reg;
  logic [7:0]    temp_offset_reg;
  logic [7:0]    temp_limit_reg;
  logic [7:0]    ptr_reg;
  fmcf_txn_t     txn_reg;
  logic          addressed_reg;
  logic          monitor_en_reg;
  logic          fan_run_reg;
  logic          over_temp_reg;
  logic          failsafe_reg;
  logic          proc_rail_prev_reg;
  logic          proc_rail_seen_reg;
  logic          vcc_s;
  logic          proc_rail_s;
  logic          pin9_s;
  logic          txn_done;
  logic          host_write;
  logic          timer_expired;
  logic          force_full;
  logic          gpio_asserted;
  logic [7:0]    status2;
  logic [7:0]    capped_duty;
  fmcf_pin_fn_t  pin_fn;

  fmcf_sync #(
    .W (3)
  ) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in ({vcc_good, proc_rail_good, pin9_in}),
    .sync_out ({vcc_s, proc_rail_s, pin9_s})
  );

  // bus engine side
  assign smb_addr_ack = smb_addr_valid && (smb_addr == SMB_DEV_ADDR);
  assign txn_done     = smb_stop && addressed_reg;
  assign host_write   = (txn_reg == FMCF_DATA) && smb_wr_valid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addressed_reg <= 1'b0;
    end else if (smb_addr_ack) begin
      addressed_reg <= 1'b1;
    end else if (smb_stop) begin
      addressed_reg <= 1'b0;
    end
  end

  // pointer first, data second, anything further ignored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txn_reg <= FMCF_IDLE;
    end else if (smb_addr_valid) begin
      if (!smb_addr_ack) begin
        txn_reg <= FMCF_IDLE;
      end else if (smb_addr_rw) begin
        txn_reg <= FMCF_READ;
      end else begin
        txn_reg <= FMCF_PTR;
      end
    end else if (smb_stop) begin
      txn_reg <= FMCF_IDLE;
    end else if (smb_wr_valid) begin
      unique case (txn_reg)
        FMCF_PTR:  txn_reg <= FMCF_DATA;
        FMCF_DATA: txn_reg <= FMCF_EXTRA;
        FMCF_IDLE, FMCF_EXTRA, FMCF_READ: txn_reg <= txn_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_reg <= PTR_RST;
    end else if ((txn_reg == FMCF_PTR) && smb_wr_valid) begin
      ptr_reg <= smb_wr_data;
    end
  end

  // writable registers; status and unmapped addresses drop writes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_cfg_reg     <= EXT_CFG_RST;
      pin_func_reg    <= PIN_FUNC_RST;
      max_duty_reg    <= MAX_DUTY_RST;
      temp_offset_reg <= TEMP_OFFSET_RST;
      temp_limit_reg  <= TEMP_LIMIT_RST;
    end else if (host_write) begin
      unique case (ptr_reg)
        REG_EXT_CFG:     ext_cfg_reg     <= smb_wr_data;
        REG_PIN_FUNC:    pin_func_reg    <= smb_wr_data;
        REG_MAX_DUTY:    max_duty_reg    <= smb_wr_data;
        REG_TEMP_OFFSET: temp_offset_reg <= smb_wr_data;
        REG_TEMP_LIMIT:  temp_limit_reg  <= smb_wr_data;
        default:         ext_cfg_reg     <= ext_cfg_reg;
      endcase
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      smb_rd_data  <= READ_UNMAPPED;
      smb_rd_valid <= 1'b0;
    end else begin
      smb_rd_valid <= smb_rd_req && (txn_reg == FMCF_READ);
      if (smb_rd_req && (txn_reg == FMCF_READ)) begin
        unique case (ptr_reg)
          REG_EXT_CFG:     smb_rd_data <= ext_cfg_reg;
          REG_PIN_FUNC:    smb_rd_data <= pin_func_reg;
          REG_MAX_DUTY:    smb_rd_data <= max_duty_reg;
          REG_TEMP_OFFSET: smb_rd_data <= temp_offset_reg;
          REG_TEMP_LIMIT:  smb_rd_data <= temp_limit_reg;
          REG_STATUS2:     smb_rd_data <= status2;
          default:         smb_rd_data <= READ_UNMAPPED;
        endcase
      end
    end
  end

  // shared pin; one function at a time so one status bit serves all
  assign pin_fn        = fmcf_pin_fn_t'(pin_func_reg[PF_SEL_MSB:PF_SEL_LSB]);
  assign gpio_asserted = (pin9_s == ext_cfg_reg[EXT_GPIO_POL_BIT]);
  assign status2       = (pin_fn == FMCF_PIN_GPIO) ? 8'(gpio_asserted) << ST2_PIN_BIT
                                                  : 8'(pin9_s) << ST2_PIN_BIT;

  always_comb begin
    pin9_out          = 1'b0;
    pin9_oe           = 1'b0;
    fourth_tach_input = 1'b0;
    thermal_limit_pin = 1'b0;
    unique case (pin_fn)
      FMCF_PIN_FOURTH_TACH: begin
        fourth_tach_input = pin9_s;
      end
      FMCF_PIN_THERMAL: begin
        // open drain: pulled low while over temperature
        thermal_limit_pin = !pin9_s;
        pin9_oe           = over_temp_reg;
      end
      FMCF_PIN_ALERT: begin
        pin9_oe = alert_req;
      end
      FMCF_PIN_GPIO: begin
        pin9_oe  = ext_cfg_reg[EXT_GPIO_DIR_BIT];
        pin9_out = pin_func_reg[PF_GPIO_OUT_BIT] ? ext_cfg_reg[EXT_GPIO_POL_BIT]
                                                 : !ext_cfg_reg[EXT_GPIO_POL_BIT];
      end
    endcase
  end

  // monitoring start
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      monitor_en_reg <= 1'b0;
    end else if ((vcc_s && proc_rail_s) || txn_done) begin
      monitor_en_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      proc_rail_prev_reg <= 1'b0;
      proc_rail_seen_reg <= 1'b0;
    end else begin
      proc_rail_prev_reg <= proc_rail_s;
      if (proc_rail_s) begin
        proc_rail_seen_reg <= 1'b1;
      end
    end
  end

  // only a rail edge starts the count, so a dead rail never fires it
  fmcf_failsafe_timer #(
    .CYCLES (FAILSAFE_CNT)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (proc_rail_s && !proc_rail_prev_reg),
    .cancel  (txn_done),
    .expired (timer_expired)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      failsafe_reg <= 1'b0;
    end else if (host_write) begin
      failsafe_reg <= 1'b0;
    end else if (timer_expired) begin
      failsafe_reg <= 1'b1;
    end
  end

  // unless over temperature or fail-safe forces full speed, fans stay off until the host programs the part
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fan_run_reg <= 1'b0;
    end else if (host_write) begin
      fan_run_reg <= 1'b1;
    end
  end

  // both codes mapped to celsius; legacy or offset-64 extended
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      over_temp_reg <= 1'b0;
    end else if (temp_valid) begin
      over_temp_reg <= fmcf_to_celsius(temp_code, legacy_range)
                     > fmcf_to_celsius(temp_limit_reg, legacy_range);
    end
  end

  assign force_full  = over_temp_reg || failsafe_reg;
  assign capped_duty = (loop_duty > max_duty_reg) ? max_duty_reg : loop_duty;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fan_duty <= DUTY_OFF;
    end else if (force_full) begin
      fan_duty <= DUTY_FULL;
    end else if (fan_run_reg) begin
      fan_duty <= capped_duty;
    end else begin
      fan_duty <= DUTY_OFF;
    end
  end

  assign monitor_enable = monitor_en_reg;
  assign legacy_range   = ext_cfg_reg[EXT_LEGACY_BIT];
  assign low_freq_drive = ext_cfg_reg[EXT_LOWFREQ_BIT];
  assign temp_offset    = temp_offset_reg;
  assign fan_full_speed = force_full;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ptr_load;
    (txn_reg == FMCF_PTR) && smb_wr_valid;
  endsequence

  sequence s_data_write;
    (txn_reg == FMCF_DATA) && smb_wr_valid;
  endsequence

  a_addr_ack_match: assert property (smb_addr_ack |-> smb_addr == SMB_DEV_ADDR)
    else $error("ack given to a foreign address");
  a_ptr_then_data: assert property (s_ptr_load ##1 (s_data_write and (ptr_reg == REG_EXT_CFG))
    |=> ext_cfg_reg == $past(smb_wr_data))
    else $error("extended config not written by second byte");
  a_ptr_loaded: assert property (s_ptr_load |=> ptr_reg == $past(smb_wr_data) && txn_reg == FMCF_DATA)
    else $error("pointer not loaded by first byte");
  a_full_on_hot: assert property ($rose(over_temp_reg) |=> fan_duty == DUTY_FULL)
    else $error("fans not at full speed when hot");
  a_fans_off_idle: assert property (!fan_run_reg && !force_full |=> fan_duty == DUTY_OFF)
    else $error("fans running before programming");
  a_failsafe_rail: assert property ($rose(failsafe_reg) |-> proc_rail_seen_reg)
    else $error("fail-safe fired without processor rail");
  a_monitor_power: assert property (vcc_s && proc_rail_s |=> monitor_en_reg)
    else $error("monitoring not started after supplies good");
  a_monitor_txn: assert property (txn_done |=> monitor_en_reg)
    else $error("monitoring not started after transaction");
  a_duty_cap_hold: assert property (fan_run_reg && !force_full |=> fan_duty <= $past(max_duty_reg))
    else $error("duty above programmed maximum");
  a_write_clears: assert property (s_data_write |=> !failsafe_reg)
    else $error("host write did not restore programmed operation");
  a_failsafe_full: assert property ($rose(timer_expired) && !host_write |=> ##1 fan_duty == DUTY_FULL)
    else $error("fail-safe did not force full speed");

endmodule // fmcf_top

// File: testbench/fmcf_smb_host.sv
`timescale 1ns/100ps
// host side of the byte-level bus; gap makes it slow between phases
module fmcf_smb_host (
  input  wire logic       clk,
  input  wire logic       smb_addr_ack,
  input  wire logic [7:0] smb_rd_data,
  input  wire logic       smb_rd_valid,
  output logic            smb_addr_valid,
  output logic [6:0]      smb_addr,
  output logic            smb_addr_rw,
  output logic            smb_wr_valid,
  output logic [7:0]      smb_wr_data,
  output logic            smb_rd_req,
  output logic            smb_stop
);
  int gap = 0;

  initial begin
    smb_addr_valid = 1'b0;
    smb_addr = 7'h00;
    smb_addr_rw = 1'b0;
    smb_wr_valid = 1'b0;
    smb_wr_data = 8'h00;
    smb_rd_req = 1'b0;
    smb_stop = 1'b0;
  end

  task automatic idle();
    repeat (gap) @(posedge clk);
  endtask

  // address, then nb write bytes or one read byte, then stop
  task automatic xfer(input logic [6:0] a, input logic rw, input int nb, input logic [7:0] b0,
                      input logic [7:0] b1, output logic acked, output logic [7:0] rd);
    rd = 8'hXX;
    @(posedge clk);
    smb_addr_valid <= 1'b1;
    smb_addr <= a;
    smb_addr_rw <= rw;
    @(posedge clk);
    acked = smb_addr_ack;
    smb_addr_valid <= 1'b0;
    smb_addr <= ~a;  // released address and write data lines never keep a stale value
    idle();
    if (rw) begin
      smb_rd_req <= 1'b1;
      @(posedge clk);
      smb_rd_req <= 1'b0;
      @(posedge clk);
      if (smb_rd_valid === 1'b1) rd = smb_rd_data;
    end else begin
      for (int i = 0; i < nb; i++) begin
        smb_wr_valid <= 1'b1;
        smb_wr_data <= (i == 0) ? b0 : b1;  // pointer byte first, data second
        @(posedge clk);
      end
      smb_wr_valid <= 1'b0;
      smb_wr_data <= ~smb_wr_data;
    end
    idle();
    smb_stop <= 1'b1;
    @(posedge clk);
    smb_stop <= 1'b0;
  endtask
endmodule  // fmcf_smb_host

// File: testbench/fmcf_tb_top.sv
`timescale 1ns/100ps
module fmcf_tb_top
  import fmcf_pkg::*;
;
  localparam int FS_CNT = 50;  // shortened fail-safe count keeps the run short
  typedef struct {logic [7:0] ptr; logic [7:0] wdata; logic [7:0] exp;} fmcf_row_t;
  logic       clk, rst_n, vcc_good, proc_rail_good, temp_valid, alert_req, pin_ext, ack;
  logic [7:0] temp_code, loop_duty, rd, smb_wr_data, smb_rd_data, temp_offset, fan_duty;
  logic [6:0] smb_addr;
  logic       smb_addr_valid, smb_addr_rw, smb_wr_valid, smb_rd_req, smb_stop, smb_addr_ack;
  logic       smb_rd_valid, pin9_out, pin9_oe, fourth_tach_input, thermal_limit_pin;
  logic       monitor_enable, legacy_range, low_freq_drive, fan_full_speed;
  wire        pin9_in;
  int         n_errors = 0, n_checks = 0, cyc = 0;
  fmcf_row_t  rows [7] = '{
    '{REG_EXT_CFG, 8'h0A, 8'h0A},
    '{REG_PIN_FUNC, 8'h02, 8'h02},
    '{REG_MAX_DUTY, 8'h80, 8'h80},
    '{REG_TEMP_OFFSET, 8'h80, 8'h80},
    '{REG_TEMP_LIMIT, 8'hA4, 8'hA4},
    '{REG_STATUS2, 8'h00, 8'h20},
    '{8'h10, 8'h5A, READ_UNMAPPED}
  };

  // pulled-up shared pin: level comes from whoever drives it
  assign pin9_in = pin9_oe ? pin9_out : pin_ext;

  fmcf_smb_host host_u (.clk(clk), .smb_addr_ack(smb_addr_ack), .smb_rd_data(smb_rd_data),
    .smb_rd_valid(smb_rd_valid), .smb_addr_valid(smb_addr_valid), .smb_addr(smb_addr),
    .smb_addr_rw(smb_addr_rw), .smb_wr_valid(smb_wr_valid), .smb_wr_data(smb_wr_data),
    .smb_rd_req(smb_rd_req), .smb_stop(smb_stop));

  fmcf_top #(.FAILSAFE_CNT(FS_CNT)) dut_u (.clk(clk), .rst_n(rst_n), .vcc_good(vcc_good),
    .proc_rail_good(proc_rail_good), .smb_addr_valid(smb_addr_valid), .smb_addr(smb_addr),
    .smb_addr_rw(smb_addr_rw), .smb_addr_ack(smb_addr_ack), .smb_wr_valid(smb_wr_valid),
    .smb_wr_data(smb_wr_data), .smb_rd_req(smb_rd_req), .smb_rd_data(smb_rd_data),
    .smb_rd_valid(smb_rd_valid), .smb_stop(smb_stop), .temp_valid(temp_valid),
    .temp_code(temp_code), .loop_duty(loop_duty), .alert_req(alert_req), .pin9_in(pin9_in),
    .pin9_out(pin9_out), .pin9_oe(pin9_oe), .fourth_tach_input(fourth_tach_input),
    .thermal_limit_pin(thermal_limit_pin), .monitor_enable(monitor_enable),
    .legacy_range(legacy_range), .low_freq_drive(low_freq_drive), .temp_offset(temp_offset),
    .fan_duty(fan_duty), .fan_full_speed(fan_full_speed));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_byte(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    host_u.xfer(SMB_DEV_ADDR, 1'b0, 2, ptr, data, ack, rd);
    tick(2);
  endtask

  task automatic rdchk(input string name, input logic [7:0] ptr, input logic [7:0] exp);
    host_u.xfer(SMB_DEV_ADDR, 1'b0, 1, ptr, 8'h00, ack, rd);
    host_u.xfer(SMB_DEV_ADDR, 1'b1, 0, 8'h00, 8'h00, ack, rd);
    chk_byte(name, exp, rd);
  endtask

  // temp_valid one cycle, then let the fan duty settle
  task automatic temp(input logic [7:0] code);
    @(posedge clk);
    temp_valid <= 1'b1;
    temp_code <= code;
    @(posedge clk);
    temp_valid <= 1'b0;
    temp_code <= ~code;
    tick(2);
  endtask

  initial begin
    rst_n = 1'b0;
    vcc_good = 1'b1;
    proc_rail_good = 1'b0;
    temp_valid = 1'b0;
    temp_code = 8'h00;
    loop_duty = 8'hC0;
    alert_req = 1'b0;
    pin_ext = 1'b1;
    do_reset();
    chk_byte("duty after reset", DUTY_OFF, fan_duty);
    chk_bit("legacy after reset", 1'b1, legacy_range);
    chk_bit("low freq after reset", 1'b0, low_freq_drive);
    tick(80);
    chk_bit("full speed without rail", 1'b0, fan_full_speed);
    chk_bit("monitor without rail", 1'b0, monitor_enable);
    host_u.xfer(7'h2F, 1'b0, 2, REG_EXT_CFG, 8'h0A, ack, rd);
    chk_bit("foreign address ack", 1'b0, ack);
    host_u.xfer(7'h2F, 1'b1, 0, 8'h00, 8'h00, ack, rd);
    chk_byte("foreign address read", 8'hXX, rd);
    tick(3);
    chk_bit("legacy kept", 1'b1, legacy_range);
    chk_bit("monitor unaddressed", 1'b0, monitor_enable);
    rdchk("ext cfg reset", REG_EXT_CFG, EXT_CFG_RST);
    tick(3);
    chk_bit("monitor after transaction", 1'b1, monitor_enable);
    rdchk("max duty reset", REG_MAX_DUTY, MAX_DUTY_RST);
    rdchk("limit reset", REG_TEMP_LIMIT, TEMP_LIMIT_RST);
    chk_byte("duty before data write", DUTY_OFF, fan_duty);
    foreach (rows[i]) begin
      wr(rows[i].ptr, rows[i].wdata);
      rdchk("table readback", rows[i].ptr, rows[i].exp);
    end
    chk_bit("low freq drive", 1'b1, low_freq_drive);
    chk_bit("extended range", 1'b0, legacy_range);
    chk_byte("offset", 8'h80, temp_offset);
    chk_byte("capped duty", 8'h80, fan_duty);
    temp(8'hFF);
    chk_byte("duty at 191 C", DUTY_FULL, fan_duty);
    temp(8'hA4);
    chk_bit("full at limit", 1'b0, fan_full_speed);
    wr(REG_EXT_CFG, 8'h01);
    wr(REG_TEMP_LIMIT, 8'h64);  // limit back in twos complement
    temp(8'hFF);
    chk_bit("full at -1 C", 1'b0, fan_full_speed);
    temp(8'h65);
    chk_byte("duty over limit", DUTY_FULL, fan_duty);
    temp(8'h00);
    alert_req <= 1'b1;
    tick(2);
    chk_bit("alert drives low", 1'b0, pin9_in);
    alert_req <= 1'b0;
    wr(REG_PIN_FUNC, 8'h01);
    pin_ext <= 1'b0;
    tick(3);
    chk_bit("thermal input", 1'b1, thermal_limit_pin);
    wr(REG_PIN_FUNC, 8'h00);
    pin_ext <= 1'b1;
    tick(3);
    chk_bit("tach input", 1'b1, fourth_tach_input);
    wr(REG_PIN_FUNC, 8'h07);
    wr(REG_EXT_CFG, 8'h0D);
    chk_bit("gpio out high", 1'b1, pin9_oe & pin9_out);
    wr(REG_EXT_CFG, 8'h05);
    chk_bit("gpio out low", 1'b0, pin9_out);
    wr(REG_EXT_CFG, 8'h09);
    chk_bit("gpio input", 1'b0, pin9_oe);
    rdchk("gpio state high", REG_STATUS2, 8'h20);
    pin_ext <= 1'b0;
    rdchk("gpio state low", REG_STATUS2, 8'h00);
    proc_rail_good <= 1'b0;
    do_reset();
    proc_rail_good <= 1'b1;
    tick(10);
    chk_bit("monitor on rails", 1'b1, monitor_enable);
    tick(30);
    chk_bit("early fail-safe", 1'b0, fan_full_speed);
    tick(20);
    chk_byte("fail-safe duty", DUTY_FULL, fan_duty);
    wr(REG_MAX_DUTY, 8'h40);
    chk_byte("duty after write", 8'h40, fan_duty);
    proc_rail_good <= 1'b0;
    do_reset();
    proc_rail_good <= 1'b1;
    tick(5);
    host_u.gap = 3;
    rdchk("slow host read", REG_PIN_FUNC, PIN_FUNC_RST);
    tick(100);
    chk_bit("fail-safe cancelled", 1'b0, fan_full_speed);
    end_sim();
  end
endmodule  // fmcf_tb_top
